/* hdl/i2m_top.sv */
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module i2m_top
	import i2m_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic       CE,
	input  wire logic [3:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       SCL_I,
	output logic            SCL_O,
	output logic            SCL_OE,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE,
	input  wire logic       GIE,
	input  wire logic       SLV_ADDR_STB,
	input  wire logic [7:0] SLV_ADDR_BYTE,
	input  wire logic       SLV_BYTE_STB,
	input  wire logic       SLV_DATA_ACCESS,
	output logic            SLV_ENABLED,
	output logic            SLV_ACK_CHOICE,
	output logic            SLV_RESUME,
	output logic            SLV_DATA_IRQ,
	output logic            SLV_MATCH_IRQ
);

	i2m_state_t st;
	i2m_state_t n;
	logic       tick;
	logic       run;
	logic       adv;
	logic       start_seen;
	logic       stop_seen;
	logic       drives_bus;
	logic       s_en;
	logic       addr_hit;

	// quarter-bit timer only runs while the engine moves bits
	assign run = (st.state == ST_START) || (st.state == ST_SHIFT)
		|| (st.state == ST_ACKIN) || (st.state == ST_ACKOUT);

	i2m_tick u_tick (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.CE      (CE),
		.RUN     (run),
		.TICK    (tick)
	);

	// phase 2 waits for scl really high, so a stretching slave stalls us
	assign adv = tick && !(st.phase == 2'h2 && !SCL_I);

	// line events from the previous pin sample
	assign start_seen = st.scl_q && SCL_I && st.sda_q && !SDA_I;
	assign stop_seen  = st.scl_q && SCL_I && !st.sda_q && SDA_I;
	assign drives_bus = (st.state == ST_SHIFT) || (st.state == ST_ACKIN)
		|| (st.state == ST_ACKOUT);
	assign s_en = st.cfg_a[SA_ENABLE];
	assign addr_hit = st.cfg_a[SA_ANY]
		|| (SLV_ADDR_BYTE[7:1] == st.own[7:1]);

	// next state: bus monitor, register port, slave flags, master engine
	always_comb begin
		n = st;
		n.s_resume = 1'b0;
		n.scl_q = SCL_I;
		n.sda_q = SDA_I;

		// line condition tracking from observed start and stop
		if (start_seen && st.state != ST_START && st.line != LINE_OWNER
			&& st.line != LINE_UNKNOWN) begin
			n.line = LINE_BUSY;
		end
		if (stop_seen) begin
			n.line = LINE_IDLE;
		end
		// our own edges on sda only move while scl is low, so any
		// start or stop seen while we shift is someone else's fault
		if ((start_seen || stop_seen) && drives_bus) begin
			n.fault = 1'b1;
			n.lost_now = 1'b1;
			n.line = LINE_BUSY;
		end

		// register writes
		if (WR) begin
			case (ADDR)
				OFS_MASTER_CTRL: begin
					n.ack_choice = WDATA[MC_ACK];
				end
				OFS_MASTER_STATE: begin
					if (WDATA[MS_READ]) n.read_flag = 1'b0;
					if (WDATA[MS_WRITE]) n.write_flag = 1'b0;
					if (WDATA[MS_STRETCH]) n.stretch = 1'b0;
					if (WDATA[MS_ARB]) n.arb_lost = 1'b0;
					if (WDATA[MS_FAULT]) n.fault = 1'b0;
					// only idle can be forced; other codes are ignored
					if (WDATA[1:0] == LINE_IDLE) n.line = LINE_IDLE;
				end
				OFS_TARGET: begin
					n.target = WDATA;
					n.read_flag = 1'b0;
					n.write_flag = 1'b0;
					n.arb_lost = 1'b0;
					n.fault = 1'b0;
					if (st.line == LINE_UNKNOWN) begin
						n.write_flag = 1'b1;
						n.fault = 1'b1;
					end else if (st.state == ST_IDLE
						|| st.state == ST_HOLD || st.state == ST_WAIT) begin
						n.stretch = 1'b0;
						n.addr_phase = 1'b1;
						n.lost_now = 1'b0;
						n.phase = 2'h0;
						if (st.line == LINE_OWNER) begin
							if (st.last_read && st.state == ST_HOLD) begin
								n.state = ST_ACKOUT;
								n.then_rep = 1'b1;
							end else begin
								n.state = ST_START;
							end
						end else if (st.line == LINE_IDLE) begin
							n.state = ST_START;
						end else begin
							n.state = ST_WAIT;
						end
					end
				end
				OFS_SHIFT: begin
					// the shifter is the data register, so no write mid-byte
					if (st.state == ST_IDLE || st.state == ST_HOLD) begin
						n.shreg = WDATA;
					end
					if (st.state == ST_HOLD) begin
						n.read_flag = 1'b0;
						n.write_flag = 1'b0;
						n.stretch = 1'b0;
						n.state = ST_SHIFT;
						n.phase = 2'h0;
						n.bitcnt = BIT_FIRST;
						n.cur_rx = 1'b0;
						n.addr_phase = 1'b0;
						n.lost_now = 1'b0;
					end
				end
				OFS_SCFG_A: begin
					n.cfg_a = WDATA & SA_MASK;
				end
				OFS_SCFG_B: begin
					n.s_ack = WDATA[SB_ACK];
					if (WDATA[1:0] != 2'h0 && s_en) begin
						n.s_byte = 1'b0;
						n.s_match = 1'b0;
						n.s_resume = 1'b1;
					end
				end
				OFS_SSTATE: begin
					if (WDATA[SS_BYTE]) n.s_byte = 1'b0;
					if (WDATA[SS_MATCH]) n.s_match = 1'b0;
				end
				OFS_SOWN: begin
					n.own = WDATA;
				end
				default: begin
				end
			endcase
		end

		// register reads; only the shift register read has a side effect
		if (RD) begin
			case (ADDR)
				OFS_MASTER_CTRL:  n.rdata = {5'h00, st.ack_choice, 2'h0};
				OFS_MASTER_STATE: n.rdata = {st.read_flag, st.write_flag,
					st.stretch, st.rx_ack, st.arb_lost, st.fault, st.line};
				OFS_TARGET:       n.rdata = st.target;
				OFS_SHIFT:        n.rdata = st.shreg;
				OFS_SCFG_A:       n.rdata = st.cfg_a;
				OFS_SCFG_B:       n.rdata = {5'h00, st.s_ack, 2'h0};
				OFS_SSTATE:       n.rdata = {st.s_byte, st.s_match, 5'h00,
					st.s_cause};
				OFS_SOWN:         n.rdata = st.own;
				default:          n.rdata = 8'h00;
			endcase
			if (ADDR == OFS_SHIFT && st.state == ST_HOLD && st.last_read) begin
				n.read_flag = 1'b0;
				n.write_flag = 1'b0;
				n.stretch = 1'b0;
				n.state = ST_ACKOUT;
				n.then_rep = 1'b0;
				n.phase = 2'h0;
				n.lost_now = 1'b0;
			end
		end

		// slave flags: clears above, sets below so a set in the same cycle wins
		if (SLV_DATA_ACCESS && s_en && st.cfg_a[SA_AUTO]) begin
			n.s_byte = 1'b0;
			n.s_match = 1'b0;
			n.s_resume = 1'b1;
		end
		if (s_en) begin
			if (SLV_BYTE_STB) n.s_byte = 1'b1;
			if (SLV_ADDR_STB && addr_hit) begin
				n.s_match = 1'b1;
				n.s_cause = 1'b0;
			end
			if (stop_seen && st.cfg_a[SA_HALT_EN]) begin
				n.s_match = 1'b1;
				n.s_cause = 1'b1;
			end
		end

		// master engine; each bit is four quarters, scl low in 0 and 1
		unique case (st.state)
			ST_IDLE, ST_HOLD: begin
			end
			ST_WAIT: begin
				if (st.line == LINE_IDLE) begin
					n.state = ST_START;
					n.phase = 2'h0;
				end
			end
			ST_START: begin
				if (adv) begin
					n.phase = 2'(st.phase + 2'h1);
					case (st.phase)
						2'h0: n.sda_low = 1'b0;
						2'h1: n.scl_low = 1'b0;
						2'h2: begin
							if (!SDA_I) begin
								// someone else holds sda: start lost
								n.arb_lost = 1'b1;
								n.write_flag = 1'b1;
								n.line = LINE_BUSY;
								n.state = ST_IDLE;
							end else begin
								n.sda_low = 1'b1;
							end
						end
						default: begin
							n.scl_low = 1'b1;
							n.state = ST_SHIFT;
							n.shreg = st.target;
							n.bitcnt = BIT_FIRST;
							n.cur_rx = 1'b0;
							n.line = LINE_OWNER;
						end
					endcase
				end
			end
			ST_SHIFT: begin
				if (adv) begin
					n.phase = 2'(st.phase + 2'h1);
					case (st.phase)
						2'h0: n.sda_low = !st.cur_rx && !st.lost_now
							&& !st.shreg[7];
						2'h1: n.scl_low = 1'b0;
						2'h2: begin
							n.shreg = {st.shreg[6:0], SDA_I};
							if (!st.cur_rx && !st.sda_low && !SDA_I
								&& !st.lost_now) begin
								n.lost_now = 1'b1;
								n.arb_lost = 1'b1;
								n.line = LINE_BUSY;
							end
						end
						default: begin
							n.scl_low = 1'b1;
							n.bitcnt = st.bitcnt - 3'h1;
							if (st.bitcnt == BIT_LAST) begin
								n.sda_low = 1'b0;
								if (!st.cur_rx) begin
									n.state = ST_ACKIN;
								end else begin
									n.last_read = 1'b1;
									n.read_flag = !st.lost_now;
									n.write_flag = st.lost_now;
									n.stretch = !st.lost_now;
									n.scl_low = !st.lost_now;
									n.state = st.lost_now ? ST_IDLE
										: ST_HOLD;
								end
							end
						end
					endcase
				end
			end
			ST_ACKIN: begin
				if (adv) begin
					n.phase = 2'(st.phase + 2'h1);
					case (st.phase)
						2'h0: n.sda_low = 1'b0;
						2'h1: n.scl_low = 1'b0;
						2'h2: n.rx_ack = SDA_I;
						default: begin
							n.scl_low = 1'b1;
							if (st.addr_phase && st.target[0]
								&& !st.rx_ack && !st.lost_now) begin
								n.state = ST_SHIFT;
								n.cur_rx = 1'b1;
								n.bitcnt = BIT_FIRST;
								n.addr_phase = 1'b0;
							end else begin
								n.write_flag = 1'b1;
								n.last_read = 1'b0;
								n.addr_phase = 1'b0;
								n.stretch = !st.lost_now;
								n.scl_low = !st.lost_now;
								n.state = st.lost_now ? ST_IDLE : ST_HOLD;
							end
						end
					endcase
				end
			end
			ST_ACKOUT: begin
				if (adv) begin
					n.phase = 2'(st.phase + 2'h1);
					case (st.phase)
						2'h0: n.sda_low = !st.ack_choice;
						2'h1: n.scl_low = 1'b0;
						2'h2: begin
							if (st.ack_choice && !SDA_I) begin
								n.lost_now = 1'b1;
								n.arb_lost = 1'b1;
								n.line = LINE_BUSY;
							end
						end
						default: begin
							n.scl_low = 1'b1;
							n.sda_low = 1'b0;
							if (st.lost_now) begin
								n.write_flag = 1'b1;
								n.scl_low = 1'b0;
								n.state = ST_IDLE;
							end else if (st.then_rep) begin
								n.state = ST_START;
							end else begin
								n.state = ST_SHIFT;
								n.cur_rx = 1'b1;
								n.bitcnt = BIT_FIRST;
							end
						end
					endcase
				end
			end
		endcase
	end

	// all block state except the quarter timer count in u_tick lives in one register
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			st <= I2M_RESET;
		end else if (CE) begin
			st <= n;
		end
	end

	// open-drain pins: only ever pull low, the bench resolves the wire
	assign SCL_O = 1'b0;
	assign SDA_O = 1'b0;
	assign SCL_OE = st.scl_low;
	assign SDA_OE = st.sda_low;
	assign RDATA = st.rdata;
	assign SLV_ENABLED = s_en;
	assign SLV_ACK_CHOICE = st.s_ack;
	assign SLV_RESUME = st.s_resume;
	// requests are gated by the cpu global enable as well
	assign SLV_DATA_IRQ = s_en && st.cfg_a[SA_BYTE_IE] && st.s_byte
		&& GIE;
	assign SLV_MATCH_IRQ = s_en && st.cfg_a[SA_MATCH_IE] && st.s_match
		&& GIE;

endmodule

/* include/i2m_pkg.sv */
package i2m_pkg;

	// register offsets, byte addresses on the plain port
	localparam logic [3:0] OFS_MASTER_CTRL  = 4'h4;
	localparam logic [3:0] OFS_MASTER_STATE = 4'h5;
	localparam logic [3:0] OFS_TARGET       = 4'h7;
	localparam logic [3:0] OFS_SHIFT        = 4'h8;
	localparam logic [3:0] OFS_SCFG_A       = 4'h9;
	localparam logic [3:0] OFS_SCFG_B       = 4'hA;
	localparam logic [3:0] OFS_SSTATE       = 4'hB;
	localparam logic [3:0] OFS_SOWN         = 4'hC;

	// master_ctrl and master_state_reg field positions
	localparam int MC_ACK     = 2;
	localparam int MS_READ    = 7;
	localparam int MS_WRITE   = 6;
	localparam int MS_STRETCH = 5;
	localparam int MS_RXACK   = 4;
	localparam int MS_ARB     = 3;
	localparam int MS_FAULT   = 2;

	// slave_config_a, slave_config_b and slave_state_reg fields
	localparam int SA_BYTE_IE  = 7;
	localparam int SA_MATCH_IE = 6;
	localparam int SA_HALT_EN  = 5;
	localparam int SA_ANY      = 2;
	localparam int SA_AUTO     = 1;
	localparam int SA_ENABLE   = 0;
	localparam int SB_ACK      = 2;
	localparam int SS_BYTE     = 7;
	localparam int SS_MATCH    = 6;
	localparam int SS_CAUSE    = 0;
	localparam logic [7:0] SA_MASK = 8'hE7;

	// line_condition_field codes
	localparam logic [1:0] LINE_UNKNOWN = 2'h0;
	localparam logic [1:0] LINE_IDLE    = 2'h1;
	localparam logic [1:0] LINE_OWNER   = 2'h2;
	localparam logic [1:0] LINE_BUSY    = 2'h3;

	// bus timing: quarter of an scl period
	localparam int CLK_PERIOD_NS  = 50;
	localparam int SCL_QUARTER_NS = 2500;
	localparam logic [5:0] QUARTER_CYC =
		6'((SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [2:0] BIT_LAST  = 3'h0;
	localparam logic [2:0] BIT_FIRST = 3'h7;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_WAIT   = 7'h02,
		ST_START  = 7'h04,
		ST_SHIFT  = 7'h08,
		ST_ACKIN  = 7'h10,
		ST_ACKOUT = 7'h20,
		ST_HOLD   = 7'h40
	} i2m_mst_t;

	typedef struct packed {
		i2m_mst_t   state;
		logic [1:0] phase;
		logic [2:0] bitcnt;
		logic [7:0] target;
		logic [7:0] shreg;
		logic       ack_choice;
		logic       read_flag;
		logic       write_flag;
		logic       stretch;
		logic       rx_ack;
		logic       arb_lost;
		logic       fault;
		logic [1:0] line;
		logic       cur_rx;
		logic       addr_phase;
		logic       last_read;
		logic       then_rep;
		logic       lost_now;
		logic       scl_low;
		logic       sda_low;
		logic       scl_q;
		logic       sda_q;
		logic [7:0] cfg_a;
		logic [7:0] own;
		logic       s_ack;
		logic       s_byte;
		logic       s_match;
		logic       s_cause;
		logic       s_resume;
		logic [7:0] rdata;
	} i2m_state_t;

	localparam i2m_state_t I2M_RESET = '{state: ST_IDLE, scl_q: 1'b1,
		sda_q: 1'b1, default: '0};

endpackage

/* hdl/i2m_tick.sv */
`timescale 1ns/100ps
module i2m_tick
	import i2m_pkg::*;
(
	input  wire logic CLK,
	input  wire logic RESET_N,
	input  wire logic CE,
	input  wire logic RUN,
	output logic      TICK
);

	logic [5:0] count;

	// restart from zero whenever the engine stops, so each op starts aligned
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			count <= 6'h00;
		end else if (CE) begin
			if (!RUN || count == QUARTER_CYC - 6'h01) begin
				count <= 6'h00;
			end else begin
				count <= count + 6'h01;
			end
		end
	end

	assign TICK = RUN && CE && (count == QUARTER_CYC - 6'h01);

endmodule

/* testbench/i2m_top_asserts.sv */
`timescale 1ns/100ps
// port-level watch on the register port and the bus drivers
module i2m_top_asserts
	import i2m_pkg::*;
(
	input wire logic       CLK,
	input wire logic       RESET_N,
	input wire logic       CE,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       SCL_I,
	input wire logic       SCL_O,
	input wire logic       SCL_OE,
	input wire logic       SDA_I,
	input wire logic       SDA_O,
	input wire logic       SDA_OE,
	input wire logic       GIE,
	input wire logic       SLV_ADDR_STB,
	input wire logic [7:0] SLV_ADDR_BYTE,
	input wire logic       SLV_BYTE_STB,
	input wire logic       SLV_DATA_ACCESS,
	input wire logic       SLV_ENABLED,
	input wire logic       SLV_ACK_CHOICE,
	input wire logic       SLV_RESUME,
	input wire logic       SLV_DATA_IRQ,
	input wire logic       SLV_MATCH_IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	// register port answers
	a_target_back:
	assert property (WR && CE && ADDR == OFS_TARGET ##1 !WR ##1 RD && CE
		&& ADDR == OFS_TARGET |=> RDATA == $past(WDATA, 3))
		else $error("target readback wrong");
	a_target_clears:
	assert property (WR && CE && ADDR == OFS_TARGET ##1 !WR ##1 RD && CE
		&& ADDR == OFS_MASTER_STATE |=> !RDATA[MS_READ] && !RDATA[MS_ARB])
		else $error("flags not cleared by target write");
	a_flags_excl:
	assert property (RD && CE && ADDR == OFS_MASTER_STATE
		|=> !(RDATA[MS_READ] && RDATA[MS_WRITE]))
		else $error("read and write flags together");
	a_hole_zero:
	assert property (RD && CE && ADDR == 4'h0 |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	// slave side outputs
	a_irq_gie:
	assert property (SLV_DATA_IRQ || SLV_MATCH_IRQ |-> GIE)
		else $error("irq without global enable");
	a_cmd_resume:
	assert property (WR && CE && ADDR == OFS_SCFG_B && WDATA[1:0] != 2'h0
		&& SLV_ENABLED |=> SLV_RESUME)
		else $error("command gave no resume");
	a_slave_off:
	assert property (WR && CE && ADDR == OFS_SCFG_A && !WDATA[SA_ENABLE]
		|=> !SLV_ENABLED)
		else $error("slave still enabled");
	// a start pulls sda with scl released, then scl follows in a quarter
	a_start_scl:
	assert property ($rose(SDA_OE) && !SCL_OE |-> ##[1:60] SCL_OE)
		else $error("start not followed by scl low");
endmodule

bind i2m_top i2m_top_asserts u_chk (.*);

/* testbench/i2m_slave_model.sv */
`timescale 1ns/100ps
// remote target: acks every byte, answers reads with TX_BYTE
module i2m_slave_model #(
	parameter logic [7:0] TX_BYTE = 8'hA5
) (
	input  wire logic       clk,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       slow,
	output logic            scl_oe,
	output logic            sda_oe,
	output logic      [7:0] got,
	output logic            mack
);
	logic       scl_q, sda_q, adr, rdd;
	logic [3:0] r;
	logic [7:0] sh, st;

	initial begin
		{sda_oe, adr, rdd, mack} = 4'h0;
		{scl_q, sda_q} = 2'h3;
		{r, sh, st, got} = '0;
	end
	// slow mode stretches scl after every fall, so the master must wait
	assign scl_oe = st != 8'h00;
	always @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (st != 8'h00)
			st <= st - 8'h01;
		if (scl && scl_q && sda_q && !sda) begin
			r <= 4'h0;
			adr <= 1'b1;
			rdd <= 1'b0;
			sda_oe <= 1'b0;
		end else if (scl && !scl_q && r < 4'h9) begin
			r <= r + 4'h1;
			if (r < 4'h8)
				sh <= {sh[6:0], sda};
			if (r == 4'h8)
				mack <= sda;
		end else if (!scl && scl_q) begin
			if (slow)
				st <= 8'h96;
			if (r == 4'h8) begin
				got <= sh;
				sda_oe <= !rdd;
			end else if (r == 4'h9) begin
				r <= 4'h0;
				adr <= 1'b0;
				rdd <= adr ? sh[0] : rdd;
				sda_oe <= (adr ? sh[0] : rdd) && !TX_BYTE[7];
			end else
				sda_oe <= rdd && !TX_BYTE[3'h7 - r[2:0]];
		end
	end
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
	import i2m_pkg::*;
	logic       clk, rst_n, wr_s, rd_s, gie, slow, mack;
	logic       d_scl, d_sda, m_scl, m_sda, dirq, mirq;
	logic [2:0] sev;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, s, got, sab;
	logic [3:0] ofs [6] = '{4'h0, OFS_MASTER_STATE, OFS_TARGET,
		OFS_SHIFT, OFS_SCFG_A, OFS_SCFG_B};
	int         err_total, checks, cyc;
	wire        scl = !(d_scl || m_scl);
	wire        sda = !(d_sda || m_sda);

	i2m_top DUT (.CLK(clk), .RESET_N(rst_n), .CE(1'b1), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
		.SCL_I(scl), .SCL_O(), .SCL_OE(d_scl),
		.SDA_I(sda), .SDA_O(), .SDA_OE(d_sda), .GIE(gie),
		.SLV_ADDR_STB(sev[2]), .SLV_ADDR_BYTE(sab),
		.SLV_BYTE_STB(sev[1]), .SLV_DATA_ACCESS(sev[0]),
		.SLV_ENABLED(), .SLV_ACK_CHOICE(), .SLV_RESUME(),
		.SLV_DATA_IRQ(dirq), .SLV_MATCH_IRQ(mirq));
	i2m_slave_model u_far (.clk(clk), .scl(scl), .sda(sda), .slow(slow),
		.scl_oe(m_scl), .sda_oe(m_sda), .got(got), .mack(mack));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard, well above the few byte transfers below
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// strobes drop at the taking edge; an idle edge follows each access
	// so no strobe is assigned twice in one step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask
	// read data stand in the cycle after the strobe, taken at its end
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic ev(input logic [2:0] v);
		sev <= v;
		@(posedge clk);
		sev <= 3'h0;
		@(posedge clk);
	endtask
	task automatic wait_bit(input int b);
		int n;
		n = 0;
		s = 8'h00;
		while (s[b] !== 1'b1 && n < 3000) begin
			rd(OFS_MASTER_STATE, s);
			n++;
		end
		if (s[b] !== 1'b1)
			chk(8'h00, 8'h01);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		{rst_n, wr_s, rd_s, gie, slow} = 5'h00;
		{sev, addr, wdata, sab} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (ofs[i]) begin
			rd(ofs[i], s);
			chk(s, 8'h00);
		end
		$display("reset values done");
		// line unknown: target write faults without touching the wires
		wr(OFS_TARGET, 8'hA0);
		rd(OFS_TARGET, s);
		chk(s, 8'hA0);
		wait_bit(MS_FAULT);
		chk(s, 8'h44);
		chk({6'h00, d_scl, d_sda}, 8'h00);
		wr(OFS_MASTER_STATE, 8'h45);
		rd(OFS_MASTER_STATE, s);
		chk(s, 8'h01);
		$display("unknown line done");
		// address write from idle, then clock hold
		wr(OFS_MASTER_CTRL, 8'h00);
		wr(OFS_TARGET, 8'hA0);
		rd(OFS_MASTER_STATE, s);
		chk(s & 8'hDC, 8'h00);
		wait_bit(MS_WRITE);
		chk(s, 8'h62);
		chk(got, 8'hA0);
		chk({6'h00, d_scl, 1'b0}, 8'h02);
		$display("address write done");
		// data write against a stretching target; mid-shift write refused
		slow <= 1'b1;
		wr(OFS_SHIFT, 8'h3C);
		rd(OFS_MASTER_STATE, s);
		chk(s & 8'hC0, 8'h00);
		wr(OFS_SHIFT, 8'hFF);
		wait_bit(MS_WRITE);
		chk(s & 8'h08, 8'h00);
		chk(got, 8'h3C);
		slow <= 1'b0;
		$display("data write done");
		// repeated start for a read, nack chosen for the next byte
		wr(OFS_MASTER_CTRL, 8'h04);
		wr(OFS_TARGET, 8'hA1);
		wait_bit(MS_READ);
		chk(s, 8'hA2);
		rd(OFS_SHIFT, s);
		chk(s, 8'hA5);
		rd(OFS_MASTER_STATE, s);
		chk(s & 8'hC0, 8'h00);
		wait_bit(MS_READ);
		chk({7'h00, mack}, 8'h01);
		rd(OFS_MASTER_CTRL, s);
		chk(s & 8'h04, 8'h04);
		$display("read done");
		// after a read the chosen ack goes out before the repeated start
		wr(OFS_TARGET, 8'hA0);
		wait_bit(MS_WRITE);
		chk(s, 8'h62);
		chk(got, 8'hA0);
		$display("repeated start done");
		// slave flags, enables and resume
		wr(OFS_SCFG_A, 8'hFF);
		rd(OFS_SCFG_A, s);
		chk(s, 8'hE7);
		gie <= 1'b1;
		ev(3'h2);
		chk({7'h00, dirq}, 8'h01);
		gie <= 1'b0;
		@(posedge clk);
		chk({7'h00, dirq}, 8'h00);
		gie <= 1'b1;
		wr(OFS_SCFG_B, 8'h02);
		chk({7'h00, dirq}, 8'h00);
		sab <= 8'h55;
		ev(3'h4);
		chk({7'h00, mirq}, 8'h01);
		rd(OFS_SSTATE, s);
		chk(s, 8'h40);
		ev(3'h1);
		chk({7'h00, mirq}, 8'h00);
		// exact match mode: only own address bits 7:1 count
		wr(OFS_SOWN, 8'h54);
		wr(OFS_SCFG_A, 8'hE3);
		sab <= 8'h57;
		ev(3'h4);
		chk({7'h00, mirq}, 8'h00);
		sab <= 8'h55;
		ev(3'h4);
		chk({7'h00, mirq}, 8'h01);
		wr(OFS_SCFG_A, 8'h00);
		ev(3'h2);
		chk({7'h00, dirq}, 8'h00);
		rd(OFS_SSTATE, s);
		chk(s, 8'h40);
		$display("slave done");
		final_report();
	end
endmodule
